// ### logic/vcotc_pkg.sv
`default_nettype none
package vcotc_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TRIM_W = 7;
	localparam int unsigned STL_W  = 3;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_TRIM = 8'h59;
	localparam logic [ADDR_W-1:0] ADDR_HOLD = 8'h5c;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h5d;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h5e;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int unsigned TRIM_MSB = 6;
	localparam int unsigned HOLD_BIT = 0;
	localparam int unsigned EN_BIT   = 0;
	localparam int unsigned STL_LSB  = 4;
	localparam int unsigned STL_MSB  = 6;
	localparam int unsigned DONE_BIT = 0;

	localparam logic [TRIM_W-1:0] TRIM_RST = 7'h00;
	localparam logic [TRIM_W-1:0] TRIM_MID = 7'h40;
	localparam logic [STL_W-1:0]  STL_RST  = 3'h4;
	localparam logic              EN_RST   = 1'b0;
	localparam logic              HOLD_RST = 1'b0;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 100;
	localparam int unsigned SETTLE_BASE_NS = 1600;
	// Least time, so the cycle count rounds up.
	localparam int unsigned SETTLE_BASE_CYC =
		(SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_CNT_W = 12;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_LOAD
	} vcotc_fsm_t;
endpackage
`default_nettype wire

// ### logic/vcotc_settle_timer.sv
`timescale 1ns/1ns
`default_nettype none
module vcotc_settle_timer #(
	parameter int unsigned CNT_W = vcotc_pkg::SETTLE_CNT_W
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	// Control
	input  wire logic                     start_i,
	input  wire logic [vcotc_pkg::STL_W-1:0] sel_i,
	// Status
	output logic                          expired_o
);
	import vcotc_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             run;
		logic             expired;
	} vcotc_tmr_st_t;

	localparam logic [CNT_W-1:0] BASE = CNT_W'(SETTLE_BASE_CYC);
	localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

	vcotc_tmr_st_t st;
	vcotc_tmr_st_t nx;

	always_comb begin
		nx         = st;
		nx.expired = 1'b0;
		if (start_i) begin
			// Interval doubles with each select step.
			nx.cnt = (BASE << sel_i) - ONE;
			nx.run = 1'b1;
		end else if (st.run) begin
			if (st.cnt == ONE) begin
				nx.run     = 1'b0;
				nx.expired = 1'b1;
			end else begin
				nx.cnt = st.cnt - ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign expired_o = st.expired;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// A restart inside the interval is legal, so only an unbroken count must expire.
	settle_base_a: assert property ((start_i && sel_i == 3'h0) ##1
		(!start_i && !expired_o) [*8] ##1 (!start_i && !expired_o) [*7] |=> expired_o)
		else $error("Settle interval at select 0 is wrong.");
	settle_longer_a: assert property ((start_i && sel_i == 3'h1) |-> ##16 !expired_o)
		else $error("Select 1 settled no longer than select 0.");
endmodule
`default_nettype wire

// ### logic/vcotc_sar.sv
`timescale 1ns/1ns
`default_nettype none
module vcotc_sar (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// Search control
	input  wire logic                      start_i,
	input  wire logic                      step_i,
	input  wire logic                      fast_i,
	// Result
	output logic [vcotc_pkg::TRIM_W-1:0]   code_o,
	output logic                           last_o
);
	import vcotc_pkg::*;

	typedef struct packed {
		logic [TRIM_W-1:0] code;
		logic [TRIM_W-1:0] mask;
	} vcotc_sar_st_t;

	localparam logic [TRIM_W-1:0] MASK_LAST = 7'h01;

	vcotc_sar_st_t st;
	vcotc_sar_st_t nx;

	always_comb begin
		nx = st;
		if (start_i) begin
			nx.code = TRIM_MID;
			nx.mask = TRIM_MID;
		end else if (step_i) begin
			// A fast oscillator means the trial bit was too high.
			if (fast_i) begin
				nx.code = st.code & ~st.mask;
			end
			nx.mask = st.mask >> 1;
			nx.code = nx.code | nx.mask;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign code_o = st.code;
	assign last_o = (st.mask == MASK_LAST);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	search_start_a: assert property (start_i |=> code_o == TRIM_MID)
		else $error("Search did not begin at mid code.");
	search_step_a: assert property ((step_i && fast_i && !start_i) |=>
		(code_o & $past(st.mask)) == 7'h00)
		else $error("Fast decision did not clear the trial bit.");
endmodule
`default_nettype wire

// ### logic/vcotc_top.sv
`timescale 1ns/1ns
`default_nettype none
module vcotc_top (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	// Register port
	input  wire logic [vcotc_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	input  wire logic [vcotc_pkg::DATA_W-1:0] reg_wdata_i,
	output logic [vcotc_pkg::DATA_W-1:0]   reg_rdata_o,
	// Oscillator compare
	input  wire logic                      vco_fast_i,
	// Synthesizer control
	output logic [vcotc_pkg::TRIM_W-1:0]   trim_code_o,
	output logic                           synth_hold_o,
	output logic                           tuning_busy_o
);
	import vcotc_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		vcotc_fsm_t        fsm;
		logic [TRIM_W-1:0] trim;
		logic              hold;
		logic [STL_W-1:0]  stl;
		logic              en;
		logic              done;
		logic              busy;
		logic [DATA_W-1:0] rdata;
	} vcotc_top_st_t;

	localparam vcotc_top_st_t ST_RST = '{
		fsm:   ST_IDLE,
		trim:  TRIM_RST,
		hold:  HOLD_RST,
		stl:   STL_RST,
		en:    EN_RST,
		done:  1'b0,
		busy:  1'b0,
		rdata: '0
	};

	vcotc_top_st_t st;
	vcotc_top_st_t nx;

	logic              wr_trim;
	logic              wr_hold;
	logic              wr_ctrl;
	logic              release_hold;
	logic              set_hold;
	logic              tmr_start;
	logic              tmr_expired;
	logic              sar_start;
	logic              sar_step;
	logic [TRIM_W-1:0] sar_code;
	logic              sar_last;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	assign wr_trim = reg_wr_i && (reg_addr_i == ADDR_TRIM);
	assign wr_hold = reg_wr_i && (reg_addr_i == ADDR_HOLD);
	assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
	assign set_hold = wr_hold && reg_wdata_i[HOLD_BIT];
	// Only a falling hold counts as a release; rewriting zero does nothing.
	assign release_hold = wr_hold && !reg_wdata_i[HOLD_BIT] && st.hold;

	// ---------------------------------------------------------------
	// Engine helpers
	// ---------------------------------------------------------------
	vcotc_settle_timer u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (tmr_start),
		.sel_i     (st.stl),
		.expired_o (tmr_expired)
	);

	vcotc_sar u_sar (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (sar_start),
		.step_i    (sar_step),
		.fast_i    (vco_fast_i),
		.code_o    (sar_code),
		.last_o    (sar_last)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		nx        = st;
		tmr_start = 1'b0;
		sar_start = 1'b0;
		sar_step  = 1'b0;
		if (wr_hold) begin
			nx.hold = reg_wdata_i[HOLD_BIT];
		end
		if (wr_ctrl) begin
			nx.stl = reg_wdata_i[STL_MSB:STL_LSB];
			nx.en  = reg_wdata_i[EN_BIT];
		end
		case (st.fsm)
			ST_IDLE: begin
				if (wr_trim) begin
					nx.trim = reg_wdata_i[TRIM_MSB:0];
				end
				if (release_hold && st.en) begin
					nx.fsm    = ST_WAIT;
					nx.done   = 1'b0;
					sar_start = 1'b1;
					tmr_start = 1'b1;
				end else if (release_hold) begin
					nx.done = 1'b1;
				end else if (set_hold) begin
					nx.done = 1'b0;
				end
			end
			ST_WAIT: begin
				// Software trim writes are ignored while the search owns the code.
				nx.trim = sar_code;
				if (set_hold) begin
					nx.fsm = ST_IDLE;
				end else if (tmr_expired) begin
					sar_step = 1'b1;
					if (sar_last) begin
						nx.fsm = ST_LOAD;
					end else begin
						tmr_start = 1'b1;
					end
				end
			end
			ST_LOAD: begin
				// Completion wins over a hold write in the same cycle.
				nx.trim = sar_code;
				nx.done = 1'b1;
				nx.fsm  = ST_IDLE;
			end
			default: begin
				nx.fsm = ST_IDLE;
			end
		endcase
		nx.busy  = (nx.fsm != ST_IDLE);
		nx.rdata = '0;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_TRIM: begin
					nx.rdata[TRIM_MSB:0] = st.trim;
				end
				ADDR_HOLD: begin
					nx.rdata[HOLD_BIT] = st.hold;
				end
				ADDR_CTRL: begin
					nx.rdata[STL_MSB:STL_LSB] = st.stl;
					nx.rdata[EN_BIT]          = st.en;
				end
				ADDR_STAT: begin
					nx.rdata[DONE_BIT] = st.done;
				end
				default: begin
					nx.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= ST_RST;
		end else begin
			st <= nx;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o   = st.rdata;
	assign trim_code_o   = st.trim;
	assign synth_hold_o  = st.hold;
	assign tuning_busy_o = st.busy;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	trim_stable_a: assert property ((st.fsm == ST_IDLE && !wr_trim) |=> $stable(trim_code_o))
		else $error("Trim code moved while idle.");
	trim_write_a: assert property ((wr_trim && st.fsm == ST_IDLE) |=> trim_code_o == $past(reg_wdata_i[TRIM_MSB:0]))
		else $error("Trim write not taken.");
	trim_read_a: assert property ((reg_rd_i && reg_addr_i == ADDR_TRIM) |=> reg_rdata_o == {1'b0, $past(trim_code_o)})
		else $error("Trim read returned wrong code.");
	cal_start_a: assert property ((release_hold && st.en) |=> tuning_busy_o && !st.done ##1 trim_code_o == TRIM_MID)
		else $error("Calibration did not start on release.");
	hold_idle_a: assert property (synth_hold_o |-> !tuning_busy_o)
		else $error("Engine ran while hold was set.");
	start_enable_a: assert property ($rose(tuning_busy_o) |-> $past(st.en) && $past(release_hold))
		else $error("Engine started without enable.");
	skip_done_a: assert property ((release_hold && !st.en) |=> st.done && !tuning_busy_o)
		else $error("Skipped calibration did not report completion.");
	finish_a: assert property ((st.fsm == ST_LOAD) |=> st.done && !tuning_busy_o && trim_code_o == $past(sar_code))
		else $error("Final code not loaded at completion.");
	status_read_a: assert property ((reg_rd_i && reg_addr_i == ADDR_STAT) |=> reg_rdata_o == {7'h00, $past(st.done)})
		else $error("Status read wrong.");
	step_wait_a: assert property (sar_step |=> !sar_step [*8])
		else $error("Search stepped before settling.");

	cal_done_c: cover property (st.fsm == ST_LOAD ##1 st.done);
	cal_skip_c: cover property (release_hold && !st.en);
	cal_abort_c: cover property (st.fsm == ST_WAIT && set_hold);
endmodule
`default_nettype wire

// ### verif/test_vco_tuning_calibration.sv
`timescale 1ns/1ns
`default_nettype none
module test_vco_tuning_calibration;
	import vcotc_pkg::*;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int LIMIT = 20000;
	logic              clk_i       = 1'b0;
	logic              sys_rst_i   = 1'b1;
	logic [ADDR_W-1:0] reg_addr_i  = 8'h00;
	logic              reg_wr_i    = 1'b0;
	logic              reg_rd_i    = 1'b0;
	logic [DATA_W-1:0] reg_wdata_i = 8'h00;
	logic [DATA_W-1:0] reg_rdata_o;
	logic              vco_fast_i  = 1'b0;
	logic [TRIM_W-1:0] trim_code_o;
	logic              synth_hold_o;
	logic              tuning_busy_o;
	logic [TRIM_W-1:0] target      = 7'h00;
	logic [DATA_W-1:0] rd_val;
	int                n_errors    = 0;
	int                n_tests     = 0;
	int                cyc         = 0;
	int                n0;
	int                n1;

	vcotc_top uut (
		.clk_i         (clk_i),
		.sys_rst_i     (sys_rst_i),
		.reg_addr_i    (reg_addr_i),
		.reg_wr_i      (reg_wr_i),
		.reg_rd_i      (reg_rd_i),
		.reg_wdata_i   (reg_wdata_i),
		.reg_rdata_o   (reg_rdata_o),
		.vco_fast_i    (vco_fast_i),
		.trim_code_o   (trim_code_o),
		.synth_hold_o  (synth_hold_o),
		.tuning_busy_o (tuning_busy_o)
	);

	always #50 clk_i = ~clk_i;

	// The oscillator reads fast whenever the trial code lies above the target.
	always @(posedge clk_i) begin
		vco_fast_i <= (trim_code_o > target);
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_errors = n_errors + 1;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask

	// Read data is registered, so it is sampled just after the taking edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, exp, d);
	endtask

	// Runs one calibration and returns the number of busy cycles seen.
	task automatic run_cal(input logic [2:0] sel, input logic [6:0] tg, output int n);
		target = tg;
		wr(ADDR_HOLD, 8'h01);
		wr(ADDR_CTRL, {1'b0, sel, 4'h1});
		repeat (3) @(posedge clk_i);
		#1;
		chk("busy before release", 8'h00, {7'h0, tuning_busy_o});
		chk("hold level", 8'h01, {7'h0, synth_hold_o});
		wr(ADDR_HOLD, 8'h00);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n = n + 1;
		end while (tuning_busy_o !== 1'b0 && n < 3000);
		chk("trim output", {1'b0, tg}, {1'b0, trim_code_o});
		rchk("trim read", ADDR_TRIM, {1'b0, tg});
		rchk("status done", ADDR_STAT, 8'h01);
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rchk("trim reset", ADDR_TRIM, 8'h00);
		rchk("hold reset", ADDR_HOLD, 8'h00);
		rchk("ctrl reset", ADDR_CTRL, 8'h40);
		wr(ADDR_STAT, 8'h01);
		rchk("status reset", ADDR_STAT, 8'h00);
		rchk("unmapped", 8'h5a, 8'h00);
		$display("test reset values done");

		wr(ADDR_TRIM, 8'h7f);
		rchk("trim stored", ADDR_TRIM, 8'h7f);
		chk("trim pins", 8'h7f, {1'b0, trim_code_o});
		$display("test trim access done");

		wr(ADDR_HOLD, 8'h01);
		wr(ADDR_CTRL, 8'h71);
		rchk("ctrl fields", ADDR_CTRL, 8'h71);
		wr(ADDR_CTRL, 8'h40);
		wr(ADDR_HOLD, 8'h00);
		repeat (2) @(posedge clk_i);
		#1;
		chk("no run when disabled", 8'h00, {7'h0, tuning_busy_o});
		rchk("skip done", ADDR_STAT, 8'h01);
		chk("trim kept", 8'h7f, {1'b0, trim_code_o});
		$display("test skipped calibration done");

		run_cal(3'h0, 7'h2b, n0);
		chk("count sel0", 8'h01, {7'h0, n0 >= 7 * 16 && n0 <= 7 * 17 + 8});
		run_cal(3'h1, 7'h55, n1);
		chk("count sel1", 8'h01, {7'h0, n1 >= 7 * 32 && n1 <= 7 * 33 + 8});
		chk("longer settle", 8'h01, {7'h0, n1 > n0});
		wr(ADDR_HOLD, 8'h01);
		rchk("done cleared", ADDR_STAT, 8'h00);
		wr(ADDR_CTRL, 8'h01);
		wr(ADDR_HOLD, 8'h00);
		run_cal(3'h0, 7'h00, n0);
		run_cal(3'h0, 7'h7f, n0);
		$display("test full calibration done");

		wr(ADDR_HOLD, 8'h01);
		wr(ADDR_CTRL, 8'h41);
		wr(ADDR_HOLD, 8'h00);
		repeat (20) @(posedge clk_i);
		#1;
		chk("busy mid run", 8'h01, {7'h0, tuning_busy_o});
		wr(ADDR_HOLD, 8'h01);
		@(posedge clk_i);
		#1;
		chk("abort busy", 8'h00, {7'h0, tuning_busy_o});
		rchk("abort status", ADDR_STAT, 8'h00);
		$display("test abort done");
		stop_test();
	end
endmodule
`default_nettype wire
